/* File: testbench/dtcc_pins.sv */
// external pin drivers facing the channel pins
module dtcc_pins (
  input wire logic [31:0] drv_lvl_i,
  input wire logic [31:0] pin_out_i,
  input wire logic [31:0] pin_oe_i,
  output logic [31:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // a driven pin reads back its own latch, otherwise the outside level
  assign pin_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & drv_lvl_i);
endmodule

/* File: testbench/dtcc_top_asserts.sv */
// concurrent checks on the capture/compare array ports
`include "dtcc_cfg.svh"
module dtcc_chk #(
  parameter int TMR_W = `DTCC_TMR_W,
  parameter int NUM_CH = `DTCC_NUM_CH
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [`DTCC_NUM_TMR-1:0] tmr_wr_i,
  input wire logic [TMR_W*`DTCC_NUM_TMR-1:0] tmr_reload_i,
  input wire logic [`DTCC_NUM_TMR-1:0] tmr_ie_i,
  input logic [TMR_W*`DTCC_NUM_TMR-1:0] tmr_value_o,
  input logic [`DTCC_NUM_TMR-1:0] tmr_ir_o,
  input logic [`DTCC_NUM_TMR-1:0] tmr_irq_o,
  input wire logic [3*NUM_CH-1:0] ch_mode_i,
  input wire logic [NUM_CH-1:0] ch_tsel_i,
  input wire logic [NUM_CH/2-1:0] ch_dbl_i,
  input wire logic ch_wr_i,
  input wire logic [NUM_CH-1:0] ch_ie_i,
  input logic [NUM_CH-1:0] ch_ir_o,
  input logic [NUM_CH-1:0] ch_irq_o,
  input wire logic [NUM_CH-1:0] ch_pin_i,
  input logic [NUM_CH-1:0] ch_pin_o,
  input logic [NUM_CH-1:0] ch_pin_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  // a wrap of timer 0 by counting, not by a software write
  sequence s_wrap0;
    $past(tmr_value_o[15:0]) == 16'hffff && tmr_value_o[15:0] != 16'hffff && !$past(tmr_wr_i[0]);
  endsequence
  sequence s_quiet0;
    ($stable(tmr_value_o[15:0]) && !ch_wr_i && ch_mode_i[2:0] == dtcc_pkg::DTCC_CMP_M1)[*3];
  endsequence
  a_wrap_reload: assert property (s_wrap0 |->
    tmr_value_o[15:0] == $past(tmr_reload_i[15:0]))
    else $error("timer 0 did not reload on wrap");
  a_ovf_flag: assert property (s_wrap0 |-> ##[0:2] tmr_ir_o[0])
    else $error("timer 0 wrap left its flag clear");
  a_tmr_gate: assert property (tmr_irq_o == (tmr_ir_o & tmr_ie_i))
    else $error("timer request not gated by enable");
  a_ch_gate: assert property (ch_irq_o == (ch_ir_o & ch_ie_i))
    else $error("channel request not gated by enable");
  a_noout_pins: assert property (ch_pin_oe_o[27:24] == 4'h0)
    else $error("input-only channel drives its pin");
  a_cap_flag: assert property ($rose(ch_pin_i[2]) &&
    ch_mode_i[8:6] == dtcc_pkg::DTCC_CAP_RISE |-> ##[1:2] ch_ir_o[2])
    else $error("rising pin edge not captured");
  a_m3_clear: assert property (s_wrap0 and (ch_mode_i[14:12] == dtcc_pkg::DTCC_CMP_M3 &&
    !ch_tsel_i[4]) |-> ##[0:2] !ch_pin_o[4])
    else $error("mode 3 pin not cleared at overflow");
  a_m1_hold: assert property (s_quiet0 |=> $stable(ch_pin_o[0]))
    else $error("mode 1 pin moved without a match");
  a_dbl_upper: assert property (ch_dbl_i[0] |-> !ch_pin_oe_o[8])
    else $error("upper channel of a pair drives its pin");
  a_m0_nopin: assert property (ch_mode_i[5:3] == dtcc_pkg::DTCC_CMP_M0 |-> !ch_pin_oe_o[1])
    else $error("mode 0 channel drives its pin");
endmodule
bind dtcc_top dtcc_chk #(.TMR_W(TMR_W), .NUM_CH(NUM_CH)) i_dtcc_chk (.sys_clk_i(sys_clk_i),
  .sys_rst_i(sys_rst_i), .tmr_wr_i(tmr_wr_i), .tmr_reload_i(tmr_reload_i), .tmr_ie_i(tmr_ie_i),
  .tmr_value_o(tmr_value_o), .tmr_ir_o(tmr_ir_o), .tmr_irq_o(tmr_irq_o), .ch_mode_i(ch_mode_i),
  .ch_tsel_i(ch_tsel_i), .ch_dbl_i(ch_dbl_i), .ch_wr_i(ch_wr_i), .ch_ie_i(ch_ie_i),
  .ch_ir_o(ch_ir_o), .ch_irq_o(ch_irq_o), .ch_pin_i(ch_pin_i), .ch_pin_o(ch_pin_o),
  .ch_pin_oe_o(ch_pin_oe_o));

/* File: testbench/dual_timebase_capture_compare_array_tb.sv */
// self-checking bench for the capture/compare array
module dual_timebase_capture_compare_array_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i, sys_rst_i, gpt_ovf_i, ch_wr_i;
  logic [3:0] tmr_run_i, tmr_wr_i, tmr_ie_i, tmr_ir_clr_i, tmr_ir_o, tmr_irq_o;
  logic [11:0] tmr_src_i;
  logic [63:0] tmr_reload_i, tmr_value_o;
  logic [15:0] tmr_wdata_i, ch_wdata_i, ch_dbl_i;
  logic [1:0] ext_cnt_i;
  logic [95:0] ch_mode_i;
  logic [4:0] ch_idx_i;
  logic [31:0] ch_tsel_i, ch_ie_i, ch_ir_clr_i, ch_ir_o, ch_irq_o, ch_pin_i, ch_pin_o;
  logic [31:0] ch_pin_oe_o, drv_lvl;
  logic [511:0] ch_value_o;
  int num_errors = 0;
  int compares = 0;
  dtcc_top i_dtcc_top (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .tmr_run_i(tmr_run_i),
    .tmr_src_i(tmr_src_i), .tmr_reload_i(tmr_reload_i), .tmr_wr_i(tmr_wr_i),
    .tmr_wdata_i(tmr_wdata_i), .gpt_ovf_i(gpt_ovf_i), .ext_cnt_i(ext_cnt_i), .tmr_ie_i(tmr_ie_i),
    .tmr_ir_clr_i(tmr_ir_clr_i), .tmr_value_o(tmr_value_o), .tmr_ir_o(tmr_ir_o),
    .tmr_irq_o(tmr_irq_o), .ch_mode_i(ch_mode_i), .ch_tsel_i(ch_tsel_i), .ch_dbl_i(ch_dbl_i),
    .ch_wr_i(ch_wr_i), .ch_idx_i(ch_idx_i), .ch_wdata_i(ch_wdata_i), .ch_ie_i(ch_ie_i),
    .ch_ir_clr_i(ch_ir_clr_i), .ch_value_o(ch_value_o), .ch_ir_o(ch_ir_o), .ch_irq_o(ch_irq_o),
    .ch_pin_i(ch_pin_i), .ch_pin_o(ch_pin_o), .ch_pin_oe_o(ch_pin_oe_o));
  dtcc_pins i_dtcc_pins (.drv_lvl_i(drv_lvl), .pin_out_i(ch_pin_o), .pin_oe_i(ch_pin_oe_o),
    .pin_o(ch_pin_i));
  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  task automatic end_sim;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic twr(input int idx, input logic [15:0] val);
    @(negedge sys_clk_i);
    tmr_wr_i[idx] = 1'b1;
    tmr_wdata_i = val;
    @(negedge sys_clk_i);
    tmr_wr_i = 4'h0;
  endtask
  task automatic cwr(input logic [4:0] idx, input logic [15:0] val);
    @(negedge sys_clk_i);
    ch_wr_i = 1'b1;
    ch_idx_i = idx;
    ch_wdata_i = val;
    @(negedge sys_clk_i);
    ch_wr_i = 1'b0;
  endtask
  // one general timer overflow pulse, then room for count and compare action
  task automatic tick;
    @(negedge sys_clk_i);
    gpt_ovf_i = 1'b1;
    @(negedge sys_clk_i);
    gpt_ovf_i = 1'b0;
    repeat (3) @(negedge sys_clk_i);
  endtask
  task automatic clr_ch;
    @(negedge sys_clk_i);
    ch_ir_clr_i = 32'hffff_ffff;
    @(negedge sys_clk_i);
    ch_ir_clr_i = 32'h0000_0000;
  endtask
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    num_errors++;
    end_sim();
  end
  initial begin
    sys_rst_i = 1'b1;
    {gpt_ovf_i, ch_wr_i, ext_cnt_i, tmr_wr_i, tmr_ir_clr_i, ch_ir_clr_i, drv_lvl} = '0;
    {tmr_wdata_i, ch_wdata_i, ch_idx_i, ch_tsel_i} = '0;
    tmr_run_i = 4'h7;
    tmr_src_i = {3'h0, 3'h7, 3'h0, 3'h6};
    tmr_reload_i = 64'h0000_0000_0000_0008;
    tmr_ie_i = 4'h1;
    ch_ie_i = 32'h0000_0001;
    ch_dbl_i = 16'h0001;
    ch_mode_i = '0;
    ch_mode_i[2:0] = dtcc_pkg::DTCC_CMP_M1;
    ch_mode_i[5:3] = dtcc_pkg::DTCC_CMP_M0;
    ch_mode_i[8:6] = dtcc_pkg::DTCC_CAP_RISE;
    ch_mode_i[11:9] = dtcc_pkg::DTCC_CMP_M2;
    ch_mode_i[14:12] = dtcc_pkg::DTCC_CMP_M3;
    ch_mode_i[74:72] = dtcc_pkg::DTCC_CMP_M1;
    repeat (3) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
    chk(tmr_value_o[31:0], 32'h0000_0000);
    chk(ch_ir_o | ch_pin_o, 32'h0000_0000);
    chk({31'h0, ch_pin_oe_o[24]}, 32'h0000_0000);
    chk({31'h0, ch_pin_oe_o[0]}, 32'h0000_0001);
    for (int i = 0; i < 5; i++) cwr(i[4:0], 16'h0010);
    // fastest prescale: one count every 8 clocks, phase unknown at the write
    twr(1, 16'h0000);
    repeat (160) @(negedge sys_clk_i);
    compares++;
    if (tmr_value_o[31:16] < 16'h0013 || tmr_value_o[31:16] > 16'h0014) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, tmr_value_o[31:16], 16'h0014);
    end
    twr(0, 16'h000f);
    tick();
    chk(tmr_value_o[15:0], 32'h0000_0010);
    chk(ch_ir_o[4:0], 32'h0000_001b);
    chk(ch_pin_o[4:0], 32'h0000_0011);
    chk(ch_irq_o[4:0], 32'h0000_0001);
    clr_ch();
    twr(0, 16'h000f);
    tick();
    chk(ch_ir_o[4:0], 32'h0000_0003);
    chk(ch_pin_o[4:0], 32'h0000_0010);
    twr(0, 16'hffff);
    tick();
    chk(tmr_value_o[15:0], 32'h0000_0008);
    chk({28'h0, tmr_ir_o}, 32'h0000_0001);
    chk({28'h0, tmr_irq_o}, 32'h0000_0001);
    chk({31'h0, ch_pin_o[4]}, 32'h0000_0000);
    @(negedge sys_clk_i);
    tmr_ir_clr_i = 4'hf;
    @(negedge sys_clk_i);
    tmr_ir_clr_i = 4'h0;
    chk({28'h0, tmr_ir_o}, 32'h0000_0000);
    clr_ch();
    drv_lvl[2] = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    chk(ch_value_o[47:32], 32'h0000_0008);
    chk({31'h0, ch_ir_o[2]}, 32'h0000_0001);
    clr_ch();
    drv_lvl[2] = 1'b0;
    repeat (4) @(negedge sys_clk_i);
    chk({31'h0, ch_ir_o[2]}, 32'h0000_0000);
    // falling-edge capture ignores the rise before it
    ch_mode_i[8:6] = dtcc_pkg::DTCC_CAP_FALL;
    drv_lvl[2] = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    chk({31'h0, ch_ir_o[2]}, 32'h0000_0000);
    twr(0, 16'h0033);
    drv_lvl[2] = 1'b0;
    repeat (4) @(negedge sys_clk_i);
    chk(ch_value_o[47:32], 32'h0000_0033);
    chk({31'h0, ch_ir_o[2]}, 32'h0000_0001);
    // both edges, taken from the second timer of the pair, held still
    ch_mode_i[8:6] = dtcc_pkg::DTCC_CAP_BOTH;
    ch_tsel_i[2] = 1'b1;
    tmr_run_i[1] = 1'b0;
    twr(1, 16'h0055);
    drv_lvl[2] = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    chk(ch_value_o[47:32], 32'h0000_0055);
    // a match on the upper partner toggles the shared lower pin
    ch_mode_i[26:24] = dtcc_pkg::DTCC_CMP_M0;
    cwr(5'h08, 16'h0034);
    tick();
    chk({31'h0, ch_pin_o[0]}, 32'h0000_0001);
    chk({31'h0, ch_ir_o[8]}, 32'h0000_0001);
    repeat (2) begin
      ext_cnt_i[1] = 1'b1;
      repeat (4) @(negedge sys_clk_i);
      ext_cnt_i[1] = 1'b0;
      repeat (4) @(negedge sys_clk_i);
    end
    chk(tmr_value_o[47:32], 32'h0000_0002);
    end_sim();
  end
endmodule

/* File: verilog/dtcc_cfg.svh */
// constants for the dual time base capture/compare array
// Overview of operation
// - Four 16-bit timers with reload registers form two pairs, one time base pair per array.
// - Each timer counts on a software-chosen prescaled system clock or on general timer overflow.
// - The first timer of each pair may also count rising edges of its external count pin.
// - Each array has 16 channels, each assignable to either timer of its pair, capture or compare.
// - Each channel owns one pin; channels 24 to 27 never drive their pin.
// - A capture latches the assigned timer on the selected pin event and raises the channel request.
// - The capture event is a rising edge, a falling edge, or both edges of the pin.
// - Compare channels are compared with their timer on each timer update and act on equality.
// - Compare mode 0 raises a request on every match and leaves the pin alone.
// - Compare mode 1 toggles the pin on every match.
// - Compare mode 2 raises at most one request per timer period.
// - Compare mode 3 sets the pin on the first match of a period and clears it on timer overflow.
// - In double-register mode two channels share one pin and a match on either toggles it; matches on both in the same cycle cancel.
// - The fastest prescaler divides by 8, giving 400 ns resolution at a 20 MHz system clock.
`ifndef DTCC_CFG_SVH
`define DTCC_CFG_SVH
`define DTCC_TMR_W 16
`define DTCC_CH_PER_ARR 16
`define DTCC_NUM_CH 32
`define DTCC_NUM_TMR 4
`define DTCC_PAIR_HALF 8
`define DTCC_NOOUT_LO 24
`define DTCC_NOOUT_HI 27
`define DTCC_PRE_BASE 8
`define DTCC_PRE_W 9
`define DTCC_SRC_MAX_PRE 3'h5
`define DTCC_CLK_MHZ 25
`define DTCC_REF_MHZ 20
`define DTCC_RES_NS 400
`endif

/* File: verilog/dtcc_pkg.sv */
// types shared by the capture/compare array files
package dtcc_pkg;
  typedef enum logic [2:0] {
    DTCC_SRC_PRE8 = 3'h0,
    DTCC_SRC_PRE16 = 3'h1,
    DTCC_SRC_PRE32 = 3'h2,
    DTCC_SRC_PRE64 = 3'h3,
    DTCC_SRC_PRE128 = 3'h4,
    DTCC_SRC_PRE256 = 3'h5,
    DTCC_SRC_GPT = 3'h6,
    DTCC_SRC_EXT = 3'h7
  } dtcc_src_t;

  typedef enum logic [2:0] {
    DTCC_CH_OFF = 3'h0,
    DTCC_CAP_RISE = 3'h1,
    DTCC_CAP_FALL = 3'h2,
    DTCC_CAP_BOTH = 3'h3,
    DTCC_CMP_M0 = 3'h4,
    DTCC_CMP_M1 = 3'h5,
    DTCC_CMP_M2 = 3'h6,
    DTCC_CMP_M3 = 3'h7
  } dtcc_mode_t;
endpackage

/* File: verilog/dtcc_timer.sv */
// one reloadable 16-bit time base with clock source selection
`include "dtcc_cfg.svh"
module dtcc_timer #(
  parameter int TMR_W = `DTCC_TMR_W,
  parameter bit HAS_EXT = 1'b1
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic run_i,
  input wire logic [2:0] src_i,
  input wire logic gpt_ovf_i,
  input wire logic ext_cnt_i,
  input wire logic wr_i,
  input wire logic [TMR_W-1:0] wdata_i,
  input wire logic [TMR_W-1:0] reload_i,
  output logic [TMR_W-1:0] value_o,
  output logic ovf_o,
  output logic upd_o
);
  localparam logic [`DTCC_PRE_W-1:0] PRE_BASE = `DTCC_PRE_W'(`DTCC_PRE_BASE);
  logic [`DTCC_PRE_W-1:0] pre_r;
  logic [`DTCC_PRE_W-1:0] pre_lim;
  logic ext_r;
  logic tick;
  logic [TMR_W-1:0] value_r;
  logic ovf_r;
  logic upd_r;

  if (TMR_W < 2) begin : g_chk
    $error("dtcc_timer: TMR_W must be at least 2");
  end

  // divide by 8 << code; code 0 is the 400 ns step at 20 MHz
  assign pre_lim = (PRE_BASE << src_i) - `DTCC_PRE_W'(1);

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || !run_i || src_i > `DTCC_SRC_MAX_PRE) begin
      pre_r <= '0;
    end else if (pre_r >= pre_lim) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_r + `DTCC_PRE_W'(1);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ext_r <= 1'b0;
    end else begin
      ext_r <= ext_cnt_i;
    end
  end

  always_comb begin
    tick = 1'b0;
    if (src_i <= `DTCC_SRC_MAX_PRE) begin
      tick = (pre_r >= pre_lim);
    end else if (src_i == dtcc_pkg::DTCC_SRC_GPT) begin
      tick = gpt_ovf_i;
    end else if (HAS_EXT) begin
      tick = ext_cnt_i && !ext_r;
    end
    tick = tick && run_i;
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      value_r <= '0;
      ovf_r <= 1'b0;
      upd_r <= 1'b0;
    end else begin
      ovf_r <= 1'b0;
      upd_r <= 1'b0;
      if (wr_i) begin
        value_r <= wdata_i;
        upd_r <= 1'b1;
      end else if (tick) begin
        upd_r <= 1'b1;
        if (&value_r) begin
          value_r <= reload_i;
          ovf_r <= 1'b1;
        end else begin
          value_r <= value_r + TMR_W'(1);
        end
      end
    end
  end

  assign value_o = value_r;
  assign ovf_o = ovf_r;
  assign upd_o = upd_r;
endmodule

/* File: verilog/dtcc_top.sv */
// two arrays of sixteen capture/compare channels on four time bases
`include "dtcc_cfg.svh"
module dtcc_top #(
  parameter int TMR_W = `DTCC_TMR_W,
  parameter int NUM_CH = `DTCC_NUM_CH
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // timers: index 0/1 first/second of array a, 2/3 of array b
  input wire logic [`DTCC_NUM_TMR-1:0] tmr_run_i,
  input wire logic [3*`DTCC_NUM_TMR-1:0] tmr_src_i,
  input wire logic [TMR_W*`DTCC_NUM_TMR-1:0] tmr_reload_i,
  input wire logic [`DTCC_NUM_TMR-1:0] tmr_wr_i,
  input wire logic [TMR_W-1:0] tmr_wdata_i,
  input wire logic gpt_ovf_i,
  input wire logic [1:0] ext_cnt_i,
  input wire logic [`DTCC_NUM_TMR-1:0] tmr_ie_i,
  input wire logic [`DTCC_NUM_TMR-1:0] tmr_ir_clr_i,
  output logic [TMR_W*`DTCC_NUM_TMR-1:0] tmr_value_o,
  output logic [`DTCC_NUM_TMR-1:0] tmr_ir_o,
  output logic [`DTCC_NUM_TMR-1:0] tmr_irq_o,
  // channels
  input wire logic [3*NUM_CH-1:0] ch_mode_i,
  input wire logic [NUM_CH-1:0] ch_tsel_i,
  input wire logic [NUM_CH/2-1:0] ch_dbl_i,
  input wire logic ch_wr_i,
  input wire logic [4:0] ch_idx_i,
  input wire logic [TMR_W-1:0] ch_wdata_i,
  input wire logic [NUM_CH-1:0] ch_ie_i,
  input wire logic [NUM_CH-1:0] ch_ir_clr_i,
  output logic [TMR_W*NUM_CH-1:0] ch_value_o,
  output logic [NUM_CH-1:0] ch_ir_o,
  output logic [NUM_CH-1:0] ch_irq_o,
  input wire logic [NUM_CH-1:0] ch_pin_i,
  output logic [NUM_CH-1:0] ch_pin_o,
  output logic [NUM_CH-1:0] ch_pin_oe_o
);
  // 20 MHz / 8 = 400 ns; at 25 MHz the same divider gives 320 ns
  localparam int RES_CYC_REF = (`DTCC_RES_NS * `DTCC_REF_MHZ) / 1000;

  logic [TMR_W-1:0] tval [`DTCC_NUM_TMR];
  logic [`DTCC_NUM_TMR-1:0] tovf;
  logic [`DTCC_NUM_TMR-1:0] tupd;
  logic [`DTCC_NUM_TMR-1:0] tmr_ir_r;
  logic [TMR_W-1:0] ch_val_r [NUM_CH];
  logic [NUM_CH-1:0] pin_prev_r;
  logic [NUM_CH-1:0] ch_ir_r;
  logic [NUM_CH-1:0] done_r;
  logic [NUM_CH-1:0] pin_r;
  logic [NUM_CH-1:0] cap_hit;
  logic [NUM_CH-1:0] cmp_hit;
  logic [NUM_CH-1:0] ch_ovf;
  logic [NUM_CH-1:0] irq_set;
  logic [TMR_W-1:0] ch_tval [NUM_CH];
  logic [NUM_CH-1:0] ch_tupd;
  logic [NUM_CH-1:0] armed;
  logic [NUM_CH-1:0] dbl_tgl;

  if (NUM_CH != `DTCC_NUM_CH || TMR_W != `DTCC_TMR_W) begin : g_chk
    $error("dtcc_top: only 32 channels of 16 bits are supported");
  end
  if (RES_CYC_REF != `DTCC_PRE_BASE) begin : g_chk_res
    $error("dtcc_top: fastest prescaler does not match the resolution");
  end

  // dbl_of and the pin steering assume each array splits into two equal halves
  if (2 * `DTCC_PAIR_HALF != `DTCC_CH_PER_ARR ||
      NUM_CH != 2 * `DTCC_CH_PER_ARR) begin : g_chk_pair
    $error("dtcc_top: double pairs must split each array in halves");
  end

  if (`DTCC_NOOUT_LO > `DTCC_NOOUT_HI || `DTCC_NOOUT_HI >= NUM_CH) begin : g_chk_noout
    $error("dtcc_top: input-only channel range lies outside the array");
  end

  // timer that serves a channel: array from index bit 4, pair member from tsel
  function automatic int tmr_of(input int ch, input logic tsel);
    tmr_of = 2 * (ch / `DTCC_CH_PER_ARR) + (tsel ? 1 : 0);
  endfunction

  function automatic dtcc_pkg::dtcc_mode_t mode_of(input int ch, input logic [3*NUM_CH-1:0] m);
    mode_of = dtcc_pkg::dtcc_mode_t'(m[3*ch +: 3]);
  endfunction

  function automatic logic is_cmp(input dtcc_pkg::dtcc_mode_t m);
    is_cmp = (m == dtcc_pkg::DTCC_CMP_M0) || (m == dtcc_pkg::DTCC_CMP_M1) ||
      (m == dtcc_pkg::DTCC_CMP_M2) || (m == dtcc_pkg::DTCC_CMP_M3);
  endfunction

  function automatic logic no_out(input int ch);
    no_out = (ch >= `DTCC_NOOUT_LO) && (ch <= `DTCC_NOOUT_HI);
  endfunction

  // double mode index: lower half of each array k pairs with k + 8
  function automatic int dbl_of(input int ch);
    dbl_of = (ch / `DTCC_CH_PER_ARR) * `DTCC_PAIR_HALF + (ch % `DTCC_PAIR_HALF);
  endfunction

  for (genvar t = 0; t < `DTCC_NUM_TMR; t++) begin : g_tmr
    dtcc_timer #(
      .TMR_W(TMR_W),
      .HAS_EXT((t % 2) == 0)
    ) u_tmr (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .run_i(tmr_run_i[t]),
      .src_i(tmr_src_i[3*t +: 3]),
      .gpt_ovf_i(gpt_ovf_i),
      .ext_cnt_i(ext_cnt_i[t/2]),
      .wr_i(tmr_wr_i[t]),
      .wdata_i(tmr_wdata_i),
      .reload_i(tmr_reload_i[TMR_W*t +: TMR_W]),
      .value_o(tval[t]),
      .ovf_o(tovf[t]),
      .upd_o(tupd[t])
    );
    assign tmr_value_o[TMR_W*t +: TMR_W] = tval[t];
  end

  // set wins over a simultaneous clear
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      tmr_ir_r <= '0;
    end else begin
      tmr_ir_r <= (tmr_ir_r & ~tmr_ir_clr_i) | tovf;
    end
  end
  assign tmr_ir_o = tmr_ir_r;
  assign tmr_irq_o = tmr_ir_r & tmr_ie_i;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      pin_prev_r <= '0;
    end else begin
      pin_prev_r <= ch_pin_i;
    end
  end

  // time base allocated to every channel, shared by capture and compare
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      ch_tval[c] = tval[tmr_of(c, ch_tsel_i[c])];
      ch_tupd[c] = tupd[tmr_of(c, ch_tsel_i[c])];
      ch_ovf[c] = tovf[tmr_of(c, ch_tsel_i[c])];
    end
  end

  // capture and compare detection
  always_comb begin
    dtcc_pkg::dtcc_mode_t m;
    logic rise;
    logic fall;
    m = dtcc_pkg::DTCC_CH_OFF;
    rise = 1'b0;
    fall = 1'b0;
    cap_hit = '0;
    cmp_hit = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      m = mode_of(c, ch_mode_i);
      rise = ch_pin_i[c] && !pin_prev_r[c];
      fall = !ch_pin_i[c] && pin_prev_r[c];
      case (m)
        dtcc_pkg::DTCC_CAP_RISE: cap_hit[c] = rise;
        dtcc_pkg::DTCC_CAP_FALL: cap_hit[c] = fall;
        dtcc_pkg::DTCC_CAP_BOTH: cap_hit[c] = rise || fall;
        default: cap_hit[c] = 1'b0;
      endcase
      // match only on a fresh timer value, so a stopped timer fires once
      cmp_hit[c] = is_cmp(m) && ch_tupd[c] && (ch_tval[c] == ch_val_r[c]);
    end
  end

  // a one-shot channel is armed again in the very cycle its timer overflows
  assign armed = ~done_r | ch_ovf;

  // double pairs: either partner toggles the lower pin, a match on both cancels
  always_comb begin
    dbl_tgl = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      if ((c % `DTCC_CH_PER_ARR) < `DTCC_PAIR_HALF) begin
        dbl_tgl[c] = ch_dbl_i[dbl_of(c)] &&
          (cmp_hit[c] ^ cmp_hit[(c + `DTCC_PAIR_HALF) % NUM_CH]);
      end
    end
  end

  // a capture beats a software write in the same cycle; that write is lost
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      for (int c = 0; c < NUM_CH; c++) begin
        ch_val_r[c] <= '0;
      end
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (cap_hit[c]) begin
          ch_val_r[c] <= ch_tval[c];
        end else if (ch_wr_i && ch_idx_i == 5'(c)) begin
          ch_val_r[c] <= ch_wdata_i;
        end
      end
    end
  end

  // one-shot modes are armed again by their timer's overflow
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      done_r <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (cmp_hit[c]) begin
          done_r[c] <= 1'b1;
        end else if (ch_ovf[c] || !is_cmp(mode_of(c, ch_mode_i))) begin
          done_r[c] <= 1'b0;
        end
      end
    end
  end

  always_comb begin
    dtcc_pkg::dtcc_mode_t m;
    m = dtcc_pkg::DTCC_CH_OFF;
    irq_set = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      m = mode_of(c, ch_mode_i);
      case (m)
        dtcc_pkg::DTCC_CAP_RISE,
        dtcc_pkg::DTCC_CAP_FALL,
        dtcc_pkg::DTCC_CAP_BOTH: irq_set[c] = cap_hit[c];
        dtcc_pkg::DTCC_CMP_M0: irq_set[c] = cmp_hit[c];
        dtcc_pkg::DTCC_CMP_M1: irq_set[c] = cmp_hit[c];
        dtcc_pkg::DTCC_CMP_M2: irq_set[c] = cmp_hit[c] && armed[c];
        dtcc_pkg::DTCC_CMP_M3: irq_set[c] = cmp_hit[c] && armed[c];
        default: irq_set[c] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ch_ir_r <= '0;
    end else begin
      ch_ir_r <= (ch_ir_r & ~ch_ir_clr_i) | irq_set;
    end
  end
  assign ch_ir_o = ch_ir_r;
  assign ch_irq_o = ch_ir_r & ch_ie_i;

  // pin latches; an upper-half channel in double mode steers its lower partner
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      pin_r <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if ((c % `DTCC_CH_PER_ARR) < `DTCC_PAIR_HALF && ch_dbl_i[dbl_of(c)]) begin
          if (dbl_tgl[c]) begin
            pin_r[c] <= !pin_r[c];
          end
        end else begin
          case (mode_of(c, ch_mode_i))
            dtcc_pkg::DTCC_CMP_M1: begin
              if (cmp_hit[c]) begin
                pin_r[c] <= !pin_r[c];
              end
            end
            dtcc_pkg::DTCC_CMP_M3: begin
              // a match in the overflow cycle itself belongs to the new period
              if (cmp_hit[c] && armed[c]) begin
                pin_r[c] <= 1'b1;
              end else if (ch_ovf[c]) begin
                pin_r[c] <= 1'b0;
              end
            end
            default: pin_r[c] <= pin_r[c];
          endcase
        end
      end
    end
  end

  always_comb begin
    dtcc_pkg::dtcc_mode_t m;
    logic dbl_lo;
    logic dbl_hi;
    m = dtcc_pkg::DTCC_CH_OFF;
    dbl_lo = 1'b0;
    dbl_hi = 1'b0;
    ch_pin_oe_o = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      m = mode_of(c, ch_mode_i);
      dbl_lo = (c % `DTCC_CH_PER_ARR) < `DTCC_PAIR_HALF && ch_dbl_i[dbl_of(c)];
      dbl_hi = (c % `DTCC_CH_PER_ARR) >= `DTCC_PAIR_HALF && ch_dbl_i[dbl_of(c)];
      if (no_out(c) || dbl_hi) begin
        ch_pin_oe_o[c] = 1'b0;
      end else begin
        ch_pin_oe_o[c] = dbl_lo || m == dtcc_pkg::DTCC_CMP_M1 ||
          m == dtcc_pkg::DTCC_CMP_M3;
      end
    end
  end

  assign ch_pin_o = pin_r;

  for (genvar c = 0; c < NUM_CH; c++) begin : g_out
    assign ch_value_o[TMR_W*c +: TMR_W] = ch_val_r[c];
  end
endmodule
